// ### rfm_consts.svh
// register map, field positions, reset values and filter timings
`ifndef RFM_CONSTS_SVH
`define RFM_CONSTS_SVH
`define RFM_CLK_MHZ        50
`define RFM_ADDR_CTRL      5'h00
`define RFM_ADDR_GPO       5'h04
`define RFM_ADDR_FLAGS     5'h08
`define RFM_ADDR_MASK      5'h0C
`define RFM_ADDR_STATUS    5'h10
`define RFM_ADDR_SUMMARY   5'h14
`define RFM_CTRL_TWSEL     8
`define RFM_CTRL_PINSEL    9
`define RFM_CTRL_SWRST     10
`define RFM_CTRL_RST       10'h000
`define RFM_GPO_RST        6'h00
`define RFM_MASK_RST       12'h000
`define RFM_ILIM_US        20
`define RFM_SHORT_US       1000
`define RFM_EN_US          3
`define RFM_OVP_ON_US      1
`define RFM_OVP_OFF_US     20
`define RFM_PG_US          6
`define RFM_ILIM_CYC       16'(`RFM_ILIM_US * `RFM_CLK_MHZ)
`define RFM_EN_CYC         16'(`RFM_EN_US * `RFM_CLK_MHZ)
`define RFM_OVP_ON_CYC     16'(`RFM_OVP_ON_US * `RFM_CLK_MHZ)
`define RFM_OVP_OFF_CYC    16'(`RFM_OVP_OFF_US * `RFM_CLK_MHZ)
`define RFM_PG_CYC         16'(`RFM_PG_US * `RFM_CLK_MHZ)
`define RFM_SHORT_CYC      (`RFM_SHORT_US * `RFM_CLK_MHZ)
`define RFM_IMMEDIATE      16'h0000
`endif

// ### rfm_pkg.sv
// types shared by the regulator fault monitor
package rfm_pkg;
  typedef enum logic [1:0] {
    RFM_SHUTDOWN,
    RFM_STANDBY,
    RFM_ACTIVE
  } rfm_mode_e;

  // latched flags, bit 11 down to bit 0
  typedef struct packed {
    logic       reset_evt;
    logic       thermal_shutdown_flag;
    logic       overvoltage_flag;
    logic       thermal_warning_flag;
    logic [1:0] linear_short_flag;
    logic [1:0] buck_short_flag;
    logic [1:0] linear_current_limit_flag;
    logic [1:0] buck_current_limit_flag;
  } rfm_flags_s;
endpackage : rfm_pkg

// ### rfm_monitor.sv
// regulator fault monitor with avalon-mm register slave
//
// Our own choices: the address map and register access over Avalon-MM.
`include "rfm_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module rfm_monitor #(
  parameter int SHORT_CYC = `RFM_SHORT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [1:0]  buck_limit_in,
  input  wire logic [1:0]  linear_limit_in,
  input  wire logic [1:0]  buck_low_in,
  input  wire logic [1:0]  linear_low_in,
  input  wire logic        thermal_warn_hi_in,
  input  wire logic        thermal_warn_lo_in,
  input  wire logic        thermal_shutdown_in,
  input  wire logic        overvoltage_in,
  input  wire logic        main_supply_input_ok,
  input  wire logic        enable_pin_in,
  input  wire logic        power_good_src_in,
  input  wire logic        external_clock_input,
  output logic      [3:0]  reg_on,
  output logic      [3:0]  reg_hiz,
  output logic      [3:0]  reg_discharge,
  output logic             first_output_out,
  output logic             first_output_oe,
  output logic             second_general_output_out,
  output logic             second_general_output_oe,
  output logic             ext_clock_out,
  output logic             power_good_pin,
  output rfm_pkg::rfm_mode_e device_mode,
  output logic             interrupt_out_n
);
  import rfm_pkg::*;

  // ----------------------------------------------------------------
  // input debounce
  // ----------------------------------------------------------------
  localparam int NF = 14;
  localparam logic [15:0] SC = 16'(SHORT_CYC);
  // 0-3 limit, 4-7 output low, 8 warn, 9 tsd, 10 ovp, 11 en, 12 supply, 13 pg
  localparam logic [15:0] RISE [NF] = '{`RFM_ILIM_CYC, `RFM_ILIM_CYC,
    `RFM_ILIM_CYC, `RFM_ILIM_CYC, SC, SC, SC, SC, `RFM_ILIM_CYC,
    `RFM_ILIM_CYC, `RFM_OVP_ON_CYC, `RFM_EN_CYC, `RFM_EN_CYC, `RFM_PG_CYC};
  localparam logic [15:0] FALL [NF] = '{`RFM_ILIM_CYC, `RFM_ILIM_CYC,
    `RFM_ILIM_CYC, `RFM_ILIM_CYC, `RFM_IMMEDIATE, `RFM_IMMEDIATE,
    `RFM_IMMEDIATE, `RFM_IMMEDIATE, `RFM_ILIM_CYC, `RFM_ILIM_CYC,
    `RFM_OVP_OFF_CYC, `RFM_EN_CYC, `RFM_IMMEDIATE, `RFM_PG_CYC};

  logic [NF-1:0] raw;
  logic [NF-1:0] qual;
  logic [NF-1:0] s1_ff;
  logic [NF-1:0] s2_ff;
  logic [NF-1:0] flt_ff;
  logic [15:0]   cnt_ff [NF];
  logic [3:0]    run_ff;
  logic [9:0]    ctrl_ff;
  logic          twsel;

  assign twsel = ctrl_ff[`RFM_CTRL_TWSEL];
  // warning threshold picked ahead of the filter
  assign raw = {power_good_src_in, main_supply_input_ok, enable_pin_in,
                overvoltage_in, thermal_shutdown_in,
                twsel ? thermal_warn_hi_in : thermal_warn_lo_in,
                linear_low_in, buck_low_in, linear_limit_in, buck_limit_in};
  // low detectors only count while their regulator runs
  assign qual = {6'h3F, run_ff, 4'hF};

  // two-stage synchroniser on every monitored input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
    end
  end

  // sample counter per signal; zero length flips at once
  for (genvar gi = 0; gi < NF; gi++) begin : g_flt
    logic [15:0] lim;
    assign lim = s2_ff[gi] ? RISE[gi] : FALL[gi];
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cnt_ff[gi] <= 16'h0000;
        flt_ff[gi] <= 1'b0;
      end else if (!qual[gi]) begin
        cnt_ff[gi] <= 16'h0000;
        flt_ff[gi] <= 1'b0;
      end else if (s2_ff[gi] == flt_ff[gi]) begin
        cnt_ff[gi] <= 16'h0000;
      end else if (lim == 16'h0000 || cnt_ff[gi] >= lim - 16'h0001) begin
        cnt_ff[gi] <= 16'h0000;
        flt_ff[gi] <= s2_ff[gi];
      end else begin
        cnt_ff[gi] <= cnt_ff[gi] + 16'h0001;
      end
    end
  end

  logic [3:0] lim_f;
  logic [3:0] low_f;
  logic       warn_f;
  logic       tsd_f;
  logic       ovp_f;
  logic       en_f;
  logic       sup_f;
  assign lim_f  = flt_ff[3:0];
  assign low_f  = flt_ff[7:4];
  assign warn_f = flt_ff[8];
  assign tsd_f  = flt_ff[9];
  assign ovp_f  = flt_ff[10];
  assign en_f   = flt_ff[11];
  assign sup_f  = flt_ff[12];

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic        req;
  logic        wr_go;
  logic        sw_rst;
  logic [11:0] clr;
  rfm_flags_s  flags_ff;
  logic [11:0] mask_ff;
  logic [5:0]  gpo_ff;
  rfm_mode_e   mode_ff;
  logic [31:0] rd_mux;

  assign req    = avs_read | avs_write;
  assign wr_go  = avs_write & ~wait_ff;
  assign sw_rst = wr_go && avs_address == `RFM_ADDR_CTRL
                  && avs_writedata[`RFM_CTRL_SWRST];

  // read mux; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      `RFM_ADDR_CTRL:    rd_mux = {22'h0, ctrl_ff};
      `RFM_ADDR_GPO:     rd_mux = {26'h0, gpo_ff};
      `RFM_ADDR_FLAGS:   rd_mux = {20'h0, flags_ff};
      `RFM_ADDR_MASK:    rd_mux = {20'h0, mask_ff};
      `RFM_ADDR_STATUS:  rd_mux = {18'h0, flt_ff[13], mode_ff, tsd_f, ovp_f,
                                  warn_f, run_ff, lim_f};
      `RFM_ADDR_SUMMARY: rd_mux = {28'h0, flags_ff.linear_short_flag
                                  | flags_ff.linear_current_limit_flag,
                                  flags_ff.buck_short_flag
                                  | flags_ff.buck_current_limit_flag};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // waitrequest drops for one cycle per request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= ~(req & wait_ff);
      if (avs_read & wait_ff) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers, reloaded by shutdown or soft reset
  // ----------------------------------------------------------------
  logic cfg_clr;
  assign cfg_clr = (mode_ff == RFM_SHUTDOWN) | sw_rst;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `RFM_CTRL_RST;
      gpo_ff  <= `RFM_GPO_RST;
      mask_ff <= `RFM_MASK_RST;
    end else if (cfg_clr) begin
      ctrl_ff <= `RFM_CTRL_RST;
      gpo_ff  <= `RFM_GPO_RST;
      mask_ff <= `RFM_MASK_RST;
    end else if (wr_go) begin
      if (avs_address == `RFM_ADDR_CTRL) ctrl_ff <= avs_writedata[9:0];
      if (avs_address == `RFM_ADDR_GPO)  gpo_ff  <= avs_writedata[5:0];
      if (avs_address == `RFM_ADDR_MASK) mask_ff <= avs_writedata[11:0];
    end
  end

  // ----------------------------------------------------------------
  // regulator run control
  // ----------------------------------------------------------------
  logic [3:0] short_hit;
  logic [3:0] short_pend;
  logic [3:0] nxt_run;
  logic       blocked;
  assign short_hit  = low_f & run_ff;
  assign short_pend = {flags_ff.linear_short_flag, flags_ff.buck_short_flag};
  assign blocked    = ovp_f | tsd_f | flags_ff.overvoltage_flag
                      | flags_ff.thermal_shutdown_flag | ~sup_f;
  // a cleared short flag lets a still-enabled regulator start again
  assign nxt_run = ctrl_ff[3:0] & {4{en_f & ~blocked}} & ~short_pend
                   & ~short_hit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_ff      <= 4'h0;
      reg_hiz     <= 4'hF;
      reg_discharge <= 4'h0;
    end else begin
      run_ff        <= nxt_run;
      reg_hiz       <= ~nxt_run;
      reg_discharge <= ~nxt_run & ctrl_ff[7:4];
    end
  end
  assign reg_on = run_ff;

  // device operating mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff <= RFM_SHUTDOWN;
    end else if (!sup_f) begin
      mode_ff <= RFM_SHUTDOWN;
    end else if (mode_ff == RFM_SHUTDOWN || tsd_f) begin
      mode_ff <= RFM_STANDBY;
    end else begin
      mode_ff <= (|run_ff) ? RFM_ACTIVE : RFM_STANDBY;
    end
  end
  assign device_mode = mode_ff;

  // ----------------------------------------------------------------
  // latched flags: set beats clear, ones clear, zeros keep
  // ----------------------------------------------------------------
  logic [3:0]  lim_d_ff;
  logic        warn_d_ff;
  rfm_flags_s  set;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lim_d_ff  <= 4'h0;
      warn_d_ff <= 1'b0;
    end else begin
      lim_d_ff  <= lim_f;
      warn_d_ff <= warn_f;
    end
  end

  always_comb begin
    set = '0;
    set.buck_current_limit_flag   = lim_f[1:0] & ~lim_d_ff[1:0];
    set.linear_current_limit_flag = lim_f[3:2] & ~lim_d_ff[3:2];
    set.buck_short_flag           = short_hit[1:0];
    set.linear_short_flag         = short_hit[3:2];
    set.thermal_warning_flag      = warn_f & ~warn_d_ff;
    set.overvoltage_flag          = ovp_f & (mode_ff != RFM_SHUTDOWN);
    set.thermal_shutdown_flag     = tsd_f;
    set.reset_evt = (mode_ff == RFM_SHUTDOWN & sup_f) | sw_rst;
  end

  // zero bits of a write leave their flag alone
  assign clr = (wr_go && avs_address == `RFM_ADDR_FLAGS)
               ? avs_writedata[11:0] : 12'h000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_ff <= '0;
    end else if (cfg_clr) begin
      flags_ff <= rfm_flags_s'({set.reset_evt, 11'h000});
    end else begin
      flags_ff <= (flags_ff & ~clr) | set;
    end
  end

  // interrupt low while any unmasked flag stands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= ~|(flags_ff & ~mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // general outputs and shared clock pin
  // ----------------------------------------------------------------
  logic [1:0] lvl;
  logic       ovp_low;
  logic       clk_s1_ff;
  logic       clk_s2_ff;
  logic       pinsel;
  assign pinsel  = ctrl_ff[`RFM_CTRL_PINSEL];
  assign ovp_low = ovp_f | flags_ff.overvoltage_flag;
  // gpo bits: 0 level, 1 open drain, 2 sequenced; 3..5 second output
  assign lvl[0] = gpo_ff[0] & (~gpo_ff[2] | en_f) & ~ovp_low;
  assign lvl[1] = gpo_ff[3] & (~gpo_ff[5] | en_f) & ~ovp_low;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_output_out          <= 1'b0;
      first_output_oe           <= 1'b0;
      second_general_output_out <= 1'b0;
      second_general_output_oe  <= 1'b0;
    end else begin
      first_output_out          <= lvl[0] & ~gpo_ff[1];
      first_output_oe           <= ~gpo_ff[1] | ~lvl[0];
      second_general_output_out <= lvl[1] & ~gpo_ff[4] & ~pinsel;
      second_general_output_oe  <= ~pinsel & (~gpo_ff[4] | ~lvl[1]);
    end
  end

  // clock input path, live only when the pin is a clock input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_s1_ff     <= 1'b0;
      clk_s2_ff     <= 1'b0;
      ext_clock_out <= 1'b0;
      power_good_pin <= 1'b0;
    end else begin
      clk_s1_ff      <= external_clock_input;
      clk_s2_ff      <= clk_s1_ff;
      ext_clock_out  <= clk_s2_ff & pinsel;
      power_good_pin <= flt_ff[13];
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_irq;
    @(posedge clk) disable iff (rst) |(flags_ff & ~mask_ff) |=> !interrupt_out_n;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked flag without interrupt");

  property p_zero_wr;
    @(posedge clk) disable iff (rst)
      wr_go && avs_address == `RFM_ADDR_FLAGS && avs_writedata == 32'h0 && !cfg_clr
      |=> flags_ff == ($past(flags_ff) | $past(set));
  endproperty
  a_zero_wr: assert property (p_zero_wr) else $error("zero write changed flags");

  property p_ovp_hold;
    @(posedge clk) disable iff (rst) ovp_f && flags_ff.overvoltage_flag && !cfg_clr
      |=> flags_ff.overvoltage_flag;
  endproperty
  a_ovp_hold: assert property (p_ovp_hold) else $error("overvoltage flag cleared");

  property p_ovp_off;
    @(posedge clk) disable iff (rst) ovp_f |=> run_ff == 4'h0 && reg_hiz == 4'hF;
  endproperty
  a_ovp_off: assert property (p_ovp_off) else $error("regulator on in overvoltage");

  property p_ovp_gpo;
    @(posedge clk) disable iff (rst) ovp_f |=> !first_output_out && first_output_oe;
  endproperty
  a_ovp_gpo: assert property (p_ovp_gpo) else $error("output not low in overvoltage");

  property p_tsd;
    @(posedge clk) disable iff (rst) tsd_f && sup_f && mode_ff != RFM_SHUTDOWN
      |=> run_ff == 4'h0 && flags_ff.thermal_shutdown_flag ##1 mode_ff == RFM_STANDBY;
  endproperty
  a_tsd: assert property (p_tsd) else $error("thermal shutdown not handled");

  property p_short;
    @(posedge clk) disable iff (rst) short_hit[0] && !cfg_clr
      |=> flags_ff.buck_short_flag[0] && !run_ff[0] ##1 !interrupt_out_n || mask_ff[4];
  endproperty
  a_short: assert property (p_short) else $error("buck short not latched");

  property p_ilim;
    @(posedge clk) disable iff (rst) $rose(lim_f[3]) && !cfg_clr
      |=> flags_ff.linear_current_limit_flag[1];
  endproperty
  a_ilim: assert property (p_ilim) else $error("linear limit not latched");

  property p_wait;
    @(posedge clk) disable iff (rst) req && wait_ff |=> !wait_ff ##1 wait_ff;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer out of time");
endmodule : rfm_monitor
`default_nettype wire

// ### rfm_host_model.sv
// host processor model: avalon-mm master reaching the fault monitor registers
`timescale 1ns/10ps
`default_nettype none
module rfm_host_model (
  input  wire logic        clk,
  output var logic  [4:0]  avs_address,
  output var logic         avs_read,
  output var logic         avs_write,
  output var logic  [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // idle bus at time zero
  initial begin
    avs_address   = 5'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
  end

  // hold request until waitrequest is sampled low, bounded
  task automatic wait_answer();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      tb_top.num_errors++;
      tb_top.print_verdict();
    end
  endtask : wait_answer

  // a write of one clears a flag, a write of zero is harmless
  task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    wait_answer();
    avs_write     <= 1'b0;
    avs_writedata <= ~d; // released data no longer shows last value
  endtask : bus_write

  // read data taken at the edge where waitrequest is low
  task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    wait_answer();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_read
endmodule : rfm_host_model
`default_nettype wire

// ### tb_top.sv
// self-checking testbench for the regulator fault monitor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rfm_pkg::*;
  localparam int SHORT_LEN = 20;
  logic clk = 1'b0, rst = 1'b1;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, interrupt_out_n;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] buck_limit_in = 2'b00, linear_limit_in = 2'b00;
  logic [1:0] buck_low_in = 2'b00, linear_low_in = 2'b00;
  logic thermal_warn_hi_in = 1'b0, thermal_warn_lo_in = 1'b0;
  logic thermal_shutdown_in = 1'b0, overvoltage_in = 1'b0;
  logic main_supply_input_ok = 1'b1, enable_pin_in = 1'b1;
  logic power_good_src_in = 1'b0, external_clock_input = 1'b0;
  logic [3:0] reg_on, reg_hiz, reg_discharge;
  logic first_output_out, first_output_oe;
  logic second_general_output_out, second_general_output_oe;
  logic ext_clock_out, power_good_pin;
  rfm_mode_e device_mode;
  int num_errors = 0, comparisons = 0;
  logic [31:0] rd;

  // ----------------------------------------
  // clock, design and host
  // ----------------------------------------
  always #10 clk = ~clk;

  rfm_monitor #(.SHORT_CYC(SHORT_LEN)) i_rfm_monitor (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .buck_limit_in(buck_limit_in),
    .linear_limit_in(linear_limit_in), .buck_low_in(buck_low_in),
    .linear_low_in(linear_low_in), .thermal_warn_hi_in(thermal_warn_hi_in),
    .thermal_warn_lo_in(thermal_warn_lo_in), .thermal_shutdown_in(thermal_shutdown_in),
    .overvoltage_in(overvoltage_in), .main_supply_input_ok(main_supply_input_ok),
    .enable_pin_in(enable_pin_in), .power_good_src_in(power_good_src_in),
    .external_clock_input(external_clock_input), .reg_on(reg_on), .reg_hiz(reg_hiz),
    .reg_discharge(reg_discharge), .first_output_out(first_output_out),
    .first_output_oe(first_output_oe),
    .second_general_output_out(second_general_output_out),
    .second_general_output_oe(second_general_output_oe),
    .ext_clock_out(ext_clock_out), .power_good_pin(power_good_pin),
    .device_mode(device_mode), .interrupt_out_n(interrupt_out_n));

  rfm_host_model i_rfm_host_model (
    .clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic check_reg(input logic [4:0] a, input logic [31:0] exp);
    i_rfm_host_model.bus_read(a, rd);
    check(rd, exp);
  endtask : check_reg

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // startup defaults, reset flag, zero write, unmapped place
  task automatic scn_startup();
    check(32'(device_mode), 32'(RFM_STANDBY));
    check(32'(interrupt_out_n), 32'h0);
    check_reg(5'h08, 32'h0000_0800);
    check_reg(5'h00, 32'h0000_0000);
    check_reg(5'h0C, 32'h0000_0000);
    check_reg(5'h18, 32'h0000_0000);
    i_rfm_host_model.bus_write(5'h08, 32'h0000_0000);
    check_reg(5'h08, 32'h0000_0800);
    i_rfm_host_model.bus_write(5'h08, 32'h0000_0800);
    repeat (3) @(posedge clk);
    check(32'(interrupt_out_n), 32'h1);
  endtask : scn_startup

  // buck and linear limiting, thermal warning, masks, live bits, threshold select
  task automatic scn_limits();
    buck_limit_in      <= 2'b01;
    linear_limit_in    <= 2'b10;
    thermal_warn_lo_in <= 1'b1;
    repeat (1010) @(posedge clk);
    check(32'(interrupt_out_n), 32'h0);
    check_reg(5'h08, 32'h0000_0109);
    check_reg(5'h10, 32'h0000_0909);
    i_rfm_host_model.bus_write(5'h0C, 32'h0000_0109);
    repeat (3) @(posedge clk);
    check(32'(interrupt_out_n), 32'h1);
    i_rfm_host_model.bus_write(5'h0C, 32'h0000_0000);
    buck_limit_in   <= 2'b00;
    linear_limit_in <= 2'b00;
    i_rfm_host_model.bus_write(5'h08, 32'h0000_0109);
    check_reg(5'h08, 32'h0000_0000);
    repeat (1010) @(posedge clk);
    check_reg(5'h10, 32'h0000_0900);
    i_rfm_host_model.bus_write(5'h00, 32'h0000_0100);
    repeat (1010) @(posedge clk);
    check_reg(5'h10, 32'h0000_0800);
    thermal_warn_lo_in <= 1'b0;
    i_rfm_host_model.bus_write(5'h00, 32'h0000_0000);
  endtask : scn_limits

  // start-up short on buck0, discharge, restart on clear
  task automatic scn_short();
    i_rfm_host_model.bus_write(5'h04, 32'h0000_0001);
    i_rfm_host_model.bus_write(5'h00, 32'h0000_0011);
    repeat (5) @(posedge clk);
    check(32'(reg_on), 32'h1);
    check(32'(device_mode), 32'(RFM_ACTIVE));
    check(32'({first_output_out, first_output_oe}), 32'h3);
    buck_low_in <= 2'b01;
    repeat (SHORT_LEN + 10) @(posedge clk);
    check(32'(reg_on), 32'h0);
    check(32'({reg_hiz, reg_discharge}), 32'hF1);
    check(32'(interrupt_out_n), 32'h0);
    check_reg(5'h08, 32'h0000_0010);
    check_reg(5'h14, 32'h0000_0001);
    buck_low_in <= 2'b00;
    i_rfm_host_model.bus_write(5'h08, 32'h0000_0010);
    repeat (3) @(posedge clk);
    check(32'(reg_on), 32'h1);
  endtask : scn_short

  // overvoltage (bit 9) or thermal shutdown (bit 10): kill, sticky flag, later clear
  task automatic scn_kill(input int b);
    if (b == 9) overvoltage_in <= 1'b1;
    else thermal_shutdown_in <= 1'b1;
    repeat (1010) @(posedge clk);
    check(32'(reg_on), 32'h0);
    check(32'(device_mode), 32'(RFM_STANDBY));
    check(32'(interrupt_out_n), 32'h0);
    if (b == 9) check(32'(first_output_out), 32'h0);
    check_reg(5'h10, 32'h0000_0800 | (32'h1 << b));
    i_rfm_host_model.bus_write(5'h08, 32'h1 << b);
    check_reg(5'h08, 32'h1 << b);
    overvoltage_in      <= 1'b0;
    thermal_shutdown_in <= 1'b0;
    repeat (1010) @(posedge clk);
    check(32'(reg_on), 32'h0);
    i_rfm_host_model.bus_write(5'h08, 32'h1 << b);
    check_reg(5'h08, 32'h0000_0000);
  endtask : scn_kill

  // supply loss, recovery into standby, then software reset
  task automatic scn_supply();
    main_supply_input_ok <= 1'b0;
    repeat (5) @(posedge clk);
    check(32'(reg_on), 32'h0);
    check(32'(device_mode), 32'(RFM_SHUTDOWN));
    main_supply_input_ok <= 1'b1;
    repeat (160) @(posedge clk);
    check(32'(device_mode), 32'(RFM_STANDBY));
    check_reg(5'h08, 32'h0000_0800);
    check_reg(5'h00, 32'h0000_0000);
    i_rfm_host_model.bus_write(5'h08, 32'h0000_0800);
    i_rfm_host_model.bus_write(5'h0C, 32'h0000_0003);
    i_rfm_host_model.bus_write(5'h00, 32'h0000_0400);
    repeat (5) @(posedge clk);
    check_reg(5'h08, 32'h0000_0800);
    check_reg(5'h0C, 32'h0000_0000);
  endtask : scn_supply

  // second output, shared clock pin and power good filter
  task automatic scn_pins();
    i_rfm_host_model.bus_write(5'h04, 32'h0000_0008);
    repeat (3) @(posedge clk);
    check(32'({second_general_output_out, second_general_output_oe}), 32'h3);
    check(32'(ext_clock_out), 32'h0);
    external_clock_input <= 1'b1;
    i_rfm_host_model.bus_write(5'h00, 32'h0000_0200);
    repeat (5) @(posedge clk);
    check(32'({second_general_output_out, second_general_output_oe}), 32'h0);
    check(32'(ext_clock_out), 32'h1);
    power_good_src_in <= 1'b1;
    repeat (290) @(posedge clk);
    check(32'(power_good_pin), 32'h0);
    repeat (20) @(posedge clk);
    check(32'(power_good_pin), 32'h1);
    check_reg(5'h10, 32'h0000_2800);
  endtask : scn_pins

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (160) @(posedge clk);
    scn_startup();
    scn_limits();
    scn_short();
    scn_kill(9);
    scn_kill(10);
    scn_supply();
    scn_pins();
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
